// file: logic/cfv_pkg.sv
// constants and types for the buck-boost converter voltage control register
// assumes one 100 MHz core clock and a management-bus decoder on the same clock
//
// Overview of operation
// RULE1: register sits at subaddress 0x19 and resets to 0xB2.
// RULE2: only password-accepted writes change the register; other writes are dropped.
// RULE3: every accepted write blanks over/undervoltage monitoring for 5 ms.
// RULE4: power-up voltage default may follow the default-select resistor input.
// RULE5: host must never program a reserved voltage code.
// RULE6: host should change the voltage code only while the converter is disabled.
// RULE7: bit 7 is read-write pulse-skip enable, reset 1; 0 forces fixed PWM.
// RULE8: bits 5-0 hold voltage code, reset 32h; 35h-3Fh reserved.
// RULE9: bit 6 always reads zero and writes to it are ignored.
`default_nettype none

package cfv_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] CONV4_VOLT_ADDR  = 8'h19;
   localparam logic [7:0] CONV4_VOLT_RESET = 8'hB2;
   localparam int         PULSE_SKIP_BIT   = 7;
   localparam int         RESERVED_BIT     = 6;
   localparam int         CODE_MSB         = 5;
   localparam int         CODE_LSB         = 0;
   localparam logic [5:0] CODE_RESET       = 6'h32;
   localparam logic [5:0] CODE_LAST_LEGAL  = 6'h34;
   localparam logic       PULSE_SKIP_RESET = 1'h1;
   localparam logic [7:0] READ_IDLE        = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // timing: supervisor blanking after a write
   localparam int CLK_PERIOD_NS       = 10;
   localparam int BLANK_TIME_MS       = 5;
   localparam int NS_PER_MS           = 1000000;
   localparam int BLANK_CYCLES_DFLT   = BLANK_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int BLANK_CNT_W         = 20;
   localparam int SYNC_STAGES         = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic       unlocked;
      logic [7:0] wdata;
   } reg_req_type;

   typedef struct packed {
      logic       pulse_skip_enable;
      logic [5:0] converter_four_voltage;
   } ctrl_type;

   typedef enum logic [1:0] {ST_SETTLE, ST_FILL, ST_LOAD, ST_RUN} strap_state_type;

endpackage

`default_nettype wire

// file: logic/blank_timer.sv
// retriggerable blanking timer for the voltage supervisor
// assumes start is a one-cycle pulse on the same clock
`default_nettype none

module blank_timer #(
   parameter int BLANK_CYCLES = cfv_pkg::BLANK_CYCLES_DFLT
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic start,
   output var  logic blank
);

   logic [cfv_pkg::BLANK_CNT_W-1:0] cnt_q;
   logic [cfv_pkg::BLANK_CNT_W-1:0] cnt_d;
   logic                            blank_q;
   logic                            blank_d;

   ////////////////////////////////////////////////////////////////////////////////
   // a new write restarts the full interval rather than extending the old one
   always_comb begin
      cnt_d = cnt_q;
      if (start) begin
         cnt_d = cfv_pkg::BLANK_CNT_W'(BLANK_CYCLES); // [RULE3]
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
      blank_d = (cnt_d != '0); // [RULE3]
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_q   <= '0;
         blank_q <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         blank_q <= blank_d;
      end
   end

   assign blank = blank_q;

endmodule

`default_nettype wire

// file: logic/converter_four_voltage_reg.sv
// voltage control register of the buck-boost converter, with write blanking
// assumes the serial bus decoder and password checker run on CORE_CLK and
// present one request per cycle; the resistor strap arrives from a pin
`default_nettype none

module converter_four_voltage_reg #(
   parameter int         BLANK_CYCLES   = cfv_pkg::BLANK_CYCLES_DFLT,
   parameter logic [5:0] ALT_CODE       = 6'h00
) (
   input  wire logic                CORE_CLK,
   input  wire logic                RESET_N,
   input  wire cfv_pkg::reg_req_type REG_REQ,
   input  wire logic                DEFAULT_SELECT_RESISTOR,
   output var  logic [7:0]          REG_RDATA,
   output var  logic                REG_RVALID,
   output var  logic                WRITE_REJECTED,
   output var  logic                PULSE_SKIP_ENABLE,
   output var  logic [5:0]          CONVERTER_FOUR_VOLTAGE,
   output var  logic                MONITOR_BLANK
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic                     sel;
   logic                     wr_ok;
   logic                     wr_bad;
   logic [cfv_pkg::SYNC_STAGES-1:0] strap_sync_q;
   logic                     strap;
   cfv_pkg::strap_state_type state_q;
   cfv_pkg::strap_state_type state_d;
   logic                     host_wrote_q;
   logic                     host_wrote_d;
   cfv_pkg::ctrl_type        ctrl_q;
   cfv_pkg::ctrl_type        ctrl_d;
   logic [7:0]               rdata_q;
   logic [7:0]               rdata_d;
   logic                     rvalid_q;
   logic                     rvalid_d;
   logic                     reject_q;
   logic                     reject_d;
   logic                     blank;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode and write qualification
   assign sel    = (REG_REQ.addr == cfv_pkg::CONV4_VOLT_ADDR); // [RULE1]
   assign wr_ok  = sel && REG_REQ.wr && REG_REQ.unlocked;      // [RULE2]
   assign wr_bad = sel && REG_REQ.wr && !REG_REQ.unlocked;     // [RULE2]

   ////////////////////////////////////////////////////////////////////////////////
   // strap synchroniser: only the last stage feeds logic
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         strap_sync_q <= '0;
      end else begin
         strap_sync_q <= {strap_sync_q[cfv_pkg::SYNC_STAGES-2:0], DEFAULT_SELECT_RESISTOR};
      end
   end

   assign strap = strap_sync_q[cfv_pkg::SYNC_STAGES-1];

   ////////////////////////////////////////////////////////////////////////////////
   // power-up sequencing: the synchroniser is cleared by reset, so two edges
   // pass before the strap is seen; then the strapped default loads once and
   // a host write before that keeps the host value
   always_comb begin
      state_d      = state_q;
      host_wrote_d = host_wrote_q | wr_ok;
      unique case (state_q)
         cfv_pkg::ST_SETTLE: begin
            state_d = cfv_pkg::ST_FILL;
         end
         cfv_pkg::ST_FILL: begin
            state_d = cfv_pkg::ST_LOAD;
         end
         cfv_pkg::ST_LOAD: begin
            state_d = cfv_pkg::ST_RUN;
         end
         cfv_pkg::ST_RUN: begin
            state_d = cfv_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         state_q      <= cfv_pkg::ST_SETTLE;
         host_wrote_q <= 1'b0;
      end else begin
         state_q      <= state_d;
         host_wrote_q <= host_wrote_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control register contents; bit 6 has no storage so it cannot be written
   always_comb begin
      ctrl_d = ctrl_q;
      if (state_q == cfv_pkg::ST_LOAD && !host_wrote_q && !wr_ok && strap) begin
         ctrl_d.converter_four_voltage = ALT_CODE; // [RULE4]
      end
      if (wr_ok) begin
         ctrl_d.pulse_skip_enable      = REG_REQ.wdata[cfv_pkg::PULSE_SKIP_BIT]; // [RULE7]
         // reserved codes are stored as written; keeping them out is the host's job
         ctrl_d.converter_four_voltage =
            REG_REQ.wdata[cfv_pkg::CODE_MSB:cfv_pkg::CODE_LSB]; // [RULE8] [RULE5] [RULE9]
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         ctrl_q.pulse_skip_enable      <= cfv_pkg::PULSE_SKIP_RESET; // [RULE1] [RULE7]
         ctrl_q.converter_four_voltage <= cfv_pkg::CODE_RESET;       // [RULE1] [RULE8]
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path and reject flag; a read in the write cycle returns the old value
   always_comb begin
      rdata_d  = cfv_pkg::READ_IDLE;
      rvalid_d = 1'b0;
      reject_d = wr_bad; // [RULE2]
      if (sel && REG_REQ.rd) begin
         rvalid_d                                          = 1'b1;
         rdata_d[cfv_pkg::PULSE_SKIP_BIT]                   = ctrl_q.pulse_skip_enable;
         rdata_d[cfv_pkg::RESERVED_BIT]                     = 1'b0; // [RULE9]
         rdata_d[cfv_pkg::CODE_MSB:cfv_pkg::CODE_LSB]       = ctrl_q.converter_four_voltage;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         rdata_q  <= cfv_pkg::READ_IDLE;
         rvalid_q <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         reject_q <= reject_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // supervisor blanking; the code is applied at once, so changing it while
   // the converter runs relies on the host's discipline
   blank_timer #(
      .BLANK_CYCLES (BLANK_CYCLES)
   ) i_blank_timer (
      .clk     (CORE_CLK),
      .reset_n (RESET_N),
      .start   (wr_ok),   // [RULE3] [RULE6]
      .blank   (blank)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops
   assign REG_RDATA              = rdata_q;
   assign REG_RVALID             = rvalid_q;
   assign WRITE_REJECTED         = reject_q;
   assign PULSE_SKIP_ENABLE      = ctrl_q.pulse_skip_enable;
   assign CONVERTER_FOUR_VOLTAGE = ctrl_q.converter_four_voltage;
   assign MONITOR_BLANK          = blank;

endmodule

`default_nettype wire

// file: verif/cfv_monitor.sv
// checker for the converter-four voltage register ports
// assumes one clock, synchronous active-low reset, bound by the bind below
`default_nettype none
module cfv_monitor #(
   parameter int BLANK_CYCLES = cfv_pkg::BLANK_CYCLES_DFLT
) (
   input wire logic                 CORE_CLK,
   input wire logic                 RESET_N,
   input wire cfv_pkg::reg_req_type REG_REQ,
   input wire logic [7:0]           REG_RDATA,
   input wire logic                 REG_RVALID,
   input wire logic                 WRITE_REJECTED,
   input wire logic                 PULSE_SKIP_ENABLE,
   input wire logic [5:0]           CONVERTER_FOUR_VOLTAGE,
   input wire logic                 MONITOR_BLANK
);
   timeunit 1ns;
   timeprecision 100ps;
   logic hit;
   logic acc;
   logic rej;
   logic rdh;
   int   cnt_q;
   int   cnt_d;
   // request decode shared by the properties
   assign hit = REG_REQ.addr == cfv_pkg::CONV4_VOLT_ADDR;
   assign acc = hit & REG_REQ.wr & REG_REQ.unlocked;
   assign rej = hit & REG_REQ.wr & !REG_REQ.unlocked;
   assign rdh = hit & REG_REQ.rd;
   // cycles since the last accepted write, parked one past the span
   always_comb cnt_d = acc ? 1 : (cnt_q > BLANK_CYCLES ? cnt_q : cnt_q + 1);
   always_ff @(posedge CORE_CLK) cnt_q <= !RESET_N ? BLANK_CYCLES + 1 : cnt_d;
   ////////////////////////////////////////
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   reset_value_a: assert property ($rose(RESET_N) |-> PULSE_SKIP_ENABLE
      && CONVERTER_FOUR_VOLTAGE == cfv_pkg::CODE_RESET) else $error("bad reset value");
   read_answer_a: assert property (rdh |=> REG_RVALID) else $error("no read answer");
   read_cause_a: assert property (REG_RVALID |-> $past(rdh))
      else $error("stray answer");
   read_data_a: assert property (REG_RVALID |-> REG_RDATA == {$past(PULSE_SKIP_ENABLE),
      1'b0, $past(CONVERTER_FOUR_VOLTAGE)}) else $error("bad read data");
   locked_write_a: assert property (rej |=> WRITE_REJECTED && $stable(PULSE_SKIP_ENABLE)
      && $stable(CONVERTER_FOUR_VOLTAGE)) else $error("locked write acted");
   reject_cause_a: assert property (WRITE_REJECTED |-> $past(rej))
      else $error("stray reject");
   write_apply_a: assert property (acc |=> {PULSE_SKIP_ENABLE,
      CONVERTER_FOUR_VOLTAGE} == {$past(REG_REQ.wdata[7]), $past(REG_REQ.wdata[5:0])})
      else $error("write lost");
   blank_span_a: assert property (MONITOR_BLANK == (cnt_q <= BLANK_CYCLES))
      else $error("blanking span wrong");
   cover property (acc);
   cover property (rej);
   cover property (rdh ##1 REG_RVALID);
endmodule
bind converter_four_voltage_reg cfv_monitor #(.BLANK_CYCLES(BLANK_CYCLES)) i_cfv_monitor (
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
   .REG_RVALID(REG_RVALID), .WRITE_REJECTED(WRITE_REJECTED),
   .PULSE_SKIP_ENABLE(PULSE_SKIP_ENABLE),
   .CONVERTER_FOUR_VOLTAGE(CONVERTER_FOUR_VOLTAGE), .MONITOR_BLANK(MONITOR_BLANK));
`default_nettype wire

// file: verif/cfv_host.sv
// host model: one management-bus request per clock
// assumes its tasks are called from a single bench process
`default_nettype none
module cfv_host (
   input  wire logic                 clk,
   output var  cfv_pkg::reg_req_type req
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle bus at time zero
   initial req = '0;
   // request changes 1 ns after the edge and holds through the next one;
   // retuning is done with the converter regarded as off
   task automatic xfer(input logic [7:0] a, input logic w, r, u, input logic [7:0] d);
      @(posedge clk);
      #1 req = '{addr: a, wr: w, rd: r, unlocked: u, wdata: d};
   endtask
endmodule
`default_nettype wire

// file: verif/converter_four_voltage_reg_bench.sv
// self-checking bench for the converter-four voltage register
// assumes the host model and checker files are compiled before it
`default_nettype none
module converter_four_voltage_reg_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 core_clk;
   logic                 reset_n;
   logic                 strap;
   logic                 rvalid;
   logic [7:0]           rdata;
   logic [7:0]           d;
   logic [7:0]           e;
   cfv_pkg::reg_req_type req;
   logic [7:0]           q[$];
   logic [7:0]           tv[4] = '{8'h00, 8'hF4, 8'h74, 8'h8F};
   int                   n_mismatch = 0;
   int                   total_checks = 0;
   ////////////////////////////////////////
   converter_four_voltage_reg #(.BLANK_CYCLES(20), .ALT_CODE(6'h15)) i_converter_four_voltage_reg (
      .CORE_CLK(core_clk), .RESET_N(reset_n), .REG_REQ(req), .DEFAULT_SELECT_RESISTOR(strap),
      .REG_RDATA(rdata), .REG_RVALID(rvalid), .WRITE_REJECTED(), .PULSE_SKIP_ENABLE(),
      .CONVERTER_FOUR_VOLTAGE(), .MONITOR_BLANK());
   cfv_host i_cfv_host (.clk(core_clk), .req(req));
   // clock: 10 ns period
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // bus helpers; only reads of the mapped address expect an answer
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      i_cfv_host.xfer(a, 1'b0, 1'b1, 1'b0, 8'h00);
      if (a == cfv_pkg::CONV4_VOLT_ADDR) q.push_back(x);
   endtask
   task automatic wr(input logic [7:0] x, input logic u);
      i_cfv_host.xfer(cfv_pkg::CONV4_VOLT_ADDR, 1'b1, 1'b0, u, x);
   endtask
   // idle the bus first so a pending request cannot stand across reset,
   // then a two-cycle reset and idle long enough for the strap load
   task automatic rst(input logic s);
      i_cfv_host.xfer(8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
      strap = s;
      reset_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 reset_n = 1'b1;
      repeat (4) i_cfv_host.xfer(8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
   endtask
   task automatic print_verdict();
      if (q.size() != 0) n_mismatch++;
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // scoreboard: oldest expected read against each answer
   always @(posedge core_clk) begin
      if (rvalid === 1'b1) begin
         e = q.size() ? q.pop_front() : 8'hXX;
         total_checks++;
         if (rdata !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, rdata, e);
         end
      end
   end
   // watchdog well beyond the expected run length
   initial begin
      #20000;
      n_mismatch++;
      print_verdict();
   end
   // main sequence
   initial begin
      reset_n = 1'b0;
      strap = 1'b1;
      void'($urandom(51));
      rst(1'b1);
      rd(8'h19, {2'h2, 6'h15});
      rst(1'b0);
      rd(8'h19, 8'hB2);
      rd(8'h18, 8'h00);
      wr(8'h05, 1'b0);
      rd(8'h19, 8'hB2);
      for (int i = 0; i < 12; i++) begin
         d = i < 4 ? tv[i] : 8'($urandom);
         if (i >= 4) d[5:0] = 6'($urandom_range(52));
         wr(d, 1'b1);
         rd(8'h19, {d[7], 1'b0, d[5:0]});
      end
      repeat (25) i_cfv_host.xfer(8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
      wr(8'h20, 1'b0);
      rd(8'h19, {d[7], 1'b0, d[5:0]});
      repeat (3) i_cfv_host.xfer(8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
